// >>> logic/smm_pkg.sv
package smm_pkg;
  // ******************************************
  // save-area slot and entry offsets from the base
  // ******************************************
  localparam logic [15:0] BASE_SLOT_OFS = 16'hfef8;
  localparam logic [15:0] IO_RESTART_OFS = 16'hff00;
  localparam logic [15:0] HALT_RESTART_OFS = 16'hff02;
  localparam logic [15:0] IO_TRAP_OFS = 16'hffa4;
  localparam logic [15:0] SAVE_TOP_OFS = 16'hffff;
  localparam logic [15:0] SAVE_BOTTOM_OFS = 16'hfe00;
  localparam logic [15:0] ENTRY_OFS = 16'h8000;
  // ******************************************
  // reset values and codes
  // ******************************************
  localparam logic [31:0] BASE_RESET = 32'h0003_0000;
  localparam int ALIGN_BITS = 15;
  localparam logic [15:0] RESTART_NEXT = 16'h0000;
  localparam logic [15:0] RESTART_REEXEC = 16'h00ff;
  localparam int TRAP_PORT_LSB = 16;
  localparam int TRAP_REP_BIT = 3;
  localparam int TRAP_STR_BIT = 2;
  localparam int TRAP_VALID_BIT = 1;
  localparam int TRAP_DIR_BIT = 0;
  localparam int HALT_FLAG_BIT = 0;
  // least edges the interrupt leads burst ready, plus the device's two sync stages
  localparam int TRAP_LEAD_EDGES = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] TRAP_HOLD = 8'(TRAP_LEAD_EDGES + SYNC_STAGES);
  // ******************************************
  // chipset register map
  // ******************************************
  localparam logic [3:0] CS_CTRL_ADR = 4'h0;
  localparam logic [3:0] CS_WAIT_ADR = 4'h4;
  localparam logic [3:0] CS_STAT_ADR = 4'h8;
  localparam int CS_ARM_BIT = 0;
  localparam int CS_RAISE_BIT = 1;
  localparam logic [7:0] CS_WAIT_RESET = 8'h02;

  typedef enum logic [2:0]
  {
    ST_RUN = 3'b000,
    ST_ENTRY = 3'b001,
    ST_SMM = 3'b011,
    ST_RESUME = 3'b010,
    ST_SHUTDOWN = 3'b110
  } smm_state_t;
endpackage

// >>> logic/smm_link_if.sv
`timescale 1ns/100ps
interface smm_link_if;
  logic mgmt_interrupt_n;
  logic burst_ready_n;
  logic io_cycle;
  logic halt_cycle;
  logic smm_active;

  modport device
  (
    input mgmt_interrupt_n,
    input burst_ready_n,
    output io_cycle,
    output halt_cycle,
    output smm_active
  );
  modport chipset
  (
    output mgmt_interrupt_n,
    output burst_ready_n,
    input io_cycle,
    input halt_cycle,
    input smm_active
  );
endinterface

// >>> logic/smm_slot_device.sv
`timescale 1ns/100ps
// Behaviour
// - reset loads base 0003_0000h
// - resume takes base from slot FEF8h
// - unaligned base at resume means shutdown
// - later entries use relocated base
// - entry writes halted flag to FF02h
// - resume halt flag selects halt or next
// - halt resume drives halt cycle; reexecute still follows restart slot 00FFh
// - trap dword holds port, rep, string, valid, dir
// - valid set only for trapped I/O
// - interrupt three edges before ready traps
// - restart 0000h continues, 00FFh reexecutes
// - entry clears restart slot
// - software checks valid before writing restart
// - second interrupt served before reexecution
// - second entry valid clear, no rewrite
// - I/O trap beats debug trap, deferred
// - device keeps debug control/status registers
// - reexecute first, then pending debug trap
// - I/O trap gives interrupt priority over debug
// - NMI only after interrupt return in mode
// - exit restores prior NMI masking
// - save area spans base+FE00h to base+FFFFh
// - entry point is base plus 8000h
module smm_slot_device
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  smm_link_if.device link,
  input wire logic I_IO_INSTR,
  input wire logic [15:0] I_IO_PORT,
  input wire logic I_IO_IN,
  input wire logic I_IO_STRING,
  input wire logic I_IO_REP,
  input wire logic I_IO_DONE,
  input wire logic I_HALTED,
  input wire logic I_DEBUG_TRAP,
  input wire logic I_RESUME,
  input wire logic I_INTERRUPT_RETURN_INSTRUCTION_DONE,
  input wire logic I_NMI,
  input wire logic I_NMI_MASK,
  input wire logic [31:0] I_DBG_CTRL,
  input wire logic [31:0] I_DBG_STAT,
  input wire logic I_SLOT_WE,
  input wire logic [15:0] I_SLOT_ADDR,
  input wire logic [31:0] I_SLOT_WDATA,
  output logic [31:0] O_SLOT_RDATA,
  output logic O_SMM_ACTIVE,
  output logic O_SHUTDOWN,
  output logic [31:0] O_ENTRY_PC,
  output logic [31:0] O_SAVE_TOP,
  output logic [31:0] O_SAVE_BOTTOM,
  output logic O_HALT_RETURN,
  output logic O_REEXEC,
  output logic O_DEBUG_TAKE,
  output logic O_NMI_TAKE,
  output logic O_NMI_MASK,
  output logic [31:0] O_DBG_CTRL,
  output logic [31:0] O_DBG_STAT
);
  // ******************************************
  // pin synchronisers
  // ******************************************
  logic smi_meta, smi_sync, smi_prev;
  logic rdy_meta, rdy_sync;

  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      smi_meta <= 1'b1;
      smi_sync <= 1'b1;
      smi_prev <= 1'b1;
      rdy_meta <= 1'b1;
      rdy_sync <= 1'b1;
    end
    else
    begin
      smi_meta <= link.mgmt_interrupt_n;
      smi_sync <= smi_meta;
      smi_prev <= smi_sync;
      rdy_meta <= link.burst_ready_n;
      rdy_sync <= rdy_meta;
    end
  end

  function automatic logic [31:0] at_base(input logic [31:0] base, input logic [15:0] ofs);
    at_base = base + {16'h0000, ofs};
  endfunction

  // ******************************************
  // control state
  // ******************************************
  smm_pkg::smm_state_t state, next_state;
  logic [31:0] base, next_base;
  logic [31:0] base_slot, next_base_slot;
  logic [15:0] restart_slot, next_restart_slot;
  logic halt_slot, next_halt_slot;
  logic [31:0] trap_dword, next_trap_dword;
  logic smi_pend, next_smi_pend;
  logic io_trap, next_io_trap;
  logic dbg_pend, next_dbg_pend;
  logic reexec_pend, next_reexec_pend;
  logic nmi_open, next_nmi_open;
  logic nmi_saved, next_nmi_saved;
  logic io_cycle, next_io_cycle;
  logic halt_cycle, next_halt_cycle;
  logic [31:0] rdata, next_rdata;
  logic halt_ret, next_halt_ret;
  logic reexec, next_reexec;
  logic dbg_take, next_dbg_take;
  logic nmi_take, next_nmi_take;
  logic nmi_mask, next_nmi_mask;
  logic [31:0] dr_ctrl, next_dr_ctrl;
  logic [31:0] dr_stat, next_dr_stat;
  logic smi_fall;
  logic dbg_hold;

  assign smi_fall = smi_prev & ~smi_sync;
  // a debug trap waits while an I/O trap is on its way or a reexecution pends
  assign dbg_hold = io_trap | reexec_pend | (io_cycle & smi_pend);

  always_comb
  begin
    next_state = state;
    next_base = base;
    next_base_slot = base_slot;
    next_restart_slot = restart_slot;
    next_halt_slot = halt_slot;
    next_trap_dword = trap_dword;
    next_smi_pend = smi_pend | smi_fall;
    next_io_trap = io_trap;
    next_dbg_pend = dbg_pend;
    next_reexec_pend = reexec_pend;
    next_nmi_open = nmi_open;
    next_nmi_saved = nmi_saved;
    next_io_cycle = 1'b0;
    next_halt_cycle = 1'b0;
    next_rdata = 32'h0000_0000;
    next_halt_ret = 1'b0;
    next_reexec = 1'b0;
    next_dbg_take = 1'b0;
    next_nmi_take = 1'b0;
    next_nmi_mask = nmi_mask;
    next_dr_ctrl = dr_ctrl;
    next_dr_stat = dr_stat;
    case (state)
      smm_pkg::ST_RUN:
      begin
        next_io_cycle = I_IO_INSTR & ~io_trap;
        // interrupt seen when the I/O cycle ends marks a trap
        if (io_cycle && !rdy_sync && (smi_pend || smi_fall))
        begin
          next_io_trap = 1'b1;
          next_io_cycle = 1'b0;
        end
        if (I_DEBUG_TRAP && dbg_hold)
          next_dbg_pend = 1'b1;
        else if (I_DEBUG_TRAP || (dbg_pend && !dbg_hold))
        begin
          next_dbg_take = 1'b1;
          next_dbg_pend = 1'b0;
        end
        // an interrupt inside an open I/O cycle waits for ready and traps
        else if ((smi_pend && !io_cycle) || io_trap)
          next_state = smm_pkg::ST_ENTRY;
        else if (reexec_pend)
        begin
          next_reexec = 1'b1;
          if (I_IO_DONE)
            next_reexec_pend = 1'b0;
        end
        next_nmi_take = I_NMI & ~I_NMI_MASK;
        next_nmi_mask = I_NMI_MASK;
        if (io_trap && !I_DEBUG_TRAP)
          next_state = smm_pkg::ST_ENTRY;
      end
      smm_pkg::ST_ENTRY:
      begin
        next_smi_pend = smi_fall;
        next_restart_slot = smm_pkg::RESTART_NEXT;
        next_halt_slot = I_HALTED;
        next_base_slot = base;
        next_trap_dword = 32'h0000_0000;
        if (io_trap && !reexec_pend)
        begin
          next_trap_dword[31:smm_pkg::TRAP_PORT_LSB] = I_IO_PORT;
          next_trap_dword[smm_pkg::TRAP_REP_BIT] = I_IO_REP;
          next_trap_dword[smm_pkg::TRAP_STR_BIT] = I_IO_STRING;
          next_trap_dword[smm_pkg::TRAP_VALID_BIT] = 1'b1;
          next_trap_dword[smm_pkg::TRAP_DIR_BIT] = I_IO_IN;
        end
        next_io_trap = 1'b0;
        next_nmi_saved = I_NMI_MASK;
        next_nmi_open = 1'b0;
        next_nmi_mask = 1'b1;
        next_dr_ctrl = I_DBG_CTRL;
        next_dr_stat = I_DBG_STAT;
        next_state = smm_pkg::ST_SMM;
      end
      smm_pkg::ST_SMM:
      begin
        if (I_SLOT_WE)
        begin
          if (I_SLOT_ADDR == smm_pkg::BASE_SLOT_OFS)
            next_base_slot = I_SLOT_WDATA;
          if (I_SLOT_ADDR == smm_pkg::IO_RESTART_OFS)
            next_restart_slot = I_SLOT_WDATA[15:0];
          if (I_SLOT_ADDR == smm_pkg::HALT_RESTART_OFS)
            next_halt_slot = I_SLOT_WDATA[smm_pkg::HALT_FLAG_BIT];
        end
        case (I_SLOT_ADDR)
          smm_pkg::BASE_SLOT_OFS: next_rdata = base_slot;
          smm_pkg::IO_RESTART_OFS: next_rdata = {16'h0000, restart_slot};
          smm_pkg::HALT_RESTART_OFS: next_rdata = {31'h0000_0000, halt_slot};
          smm_pkg::IO_TRAP_OFS: next_rdata = trap_dword;
          default: next_rdata = 32'h0000_0000;
        endcase
        if (I_INTERRUPT_RETURN_INSTRUCTION_DONE)
          next_nmi_open = 1'b1;
        if (nmi_open)
        begin
          next_nmi_mask = 1'b0;
          next_nmi_take = I_NMI;
        end
        if (I_RESUME)
          next_state = smm_pkg::ST_RESUME;
      end
      smm_pkg::ST_RESUME:
      begin
        if (base_slot[smm_pkg::ALIGN_BITS-1:0] != '0)
          next_state = smm_pkg::ST_SHUTDOWN;
        else
        begin
          next_base = base_slot;
          next_state = smm_pkg::ST_RUN;
          next_nmi_mask = nmi_saved;
          next_halt_cycle = halt_slot;
          next_halt_ret = halt_slot;
          if (restart_slot == smm_pkg::RESTART_REEXEC)
            next_reexec_pend = 1'b1;
        end
      end
      smm_pkg::ST_SHUTDOWN:
      begin
        next_smi_pend = 1'b0;
      end
      default:
      begin
        next_state = smm_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state <= smm_pkg::ST_RUN;
      base <= smm_pkg::BASE_RESET;
      base_slot <= smm_pkg::BASE_RESET;
      restart_slot <= smm_pkg::RESTART_NEXT;
      halt_slot <= 1'b0;
      trap_dword <= 32'h0000_0000;
      smi_pend <= 1'b0;
      io_trap <= 1'b0;
      dbg_pend <= 1'b0;
      reexec_pend <= 1'b0;
      nmi_open <= 1'b0;
      nmi_saved <= 1'b0;
      io_cycle <= 1'b0;
      halt_cycle <= 1'b0;
      rdata <= 32'h0000_0000;
      halt_ret <= 1'b0;
      reexec <= 1'b0;
      dbg_take <= 1'b0;
      nmi_take <= 1'b0;
      nmi_mask <= 1'b0;
      dr_ctrl <= 32'h0000_0000;
      dr_stat <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      base <= next_base;
      base_slot <= next_base_slot;
      restart_slot <= next_restart_slot;
      halt_slot <= next_halt_slot;
      trap_dword <= next_trap_dword;
      smi_pend <= next_smi_pend;
      io_trap <= next_io_trap;
      dbg_pend <= next_dbg_pend;
      reexec_pend <= next_reexec_pend;
      nmi_open <= next_nmi_open;
      nmi_saved <= next_nmi_saved;
      io_cycle <= next_io_cycle;
      halt_cycle <= next_halt_cycle;
      rdata <= next_rdata;
      halt_ret <= next_halt_ret;
      reexec <= next_reexec;
      dbg_take <= next_dbg_take;
      nmi_take <= next_nmi_take;
      nmi_mask <= next_nmi_mask;
      dr_ctrl <= next_dr_ctrl;
      dr_stat <= next_dr_stat;
    end
  end

  // ******************************************
  // address outputs from the active base
  // ******************************************
  logic [31:0] entry_pc, save_top, save_bottom;
  logic smm_act, shut;

  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      entry_pc <= 32'h0000_0000;
      save_top <= 32'h0000_0000;
      save_bottom <= 32'h0000_0000;
      smm_act <= 1'b0;
      shut <= 1'b0;
    end
    else
    begin
      smm_act <= (next_state == smm_pkg::ST_SMM);
      shut <= (next_state == smm_pkg::ST_SHUTDOWN);
      entry_pc <= at_base(base, smm_pkg::ENTRY_OFS);
      save_top <= at_base(base, smm_pkg::SAVE_TOP_OFS);
      save_bottom <= at_base(base, smm_pkg::SAVE_BOTTOM_OFS);
    end
  end

  assign link.io_cycle = io_cycle;
  assign link.halt_cycle = halt_cycle;
  assign link.smm_active = smm_act;
  assign O_SLOT_RDATA = rdata;
  assign O_SMM_ACTIVE = smm_act;
  assign O_SHUTDOWN = shut;
  assign O_ENTRY_PC = entry_pc;
  assign O_SAVE_TOP = save_top;
  assign O_SAVE_BOTTOM = save_bottom;
  assign O_HALT_RETURN = halt_ret;
  assign O_REEXEC = reexec;
  assign O_DEBUG_TAKE = dbg_take;
  assign O_NMI_TAKE = nmi_take;
  assign O_NMI_MASK = nmi_mask;
  assign O_DBG_CTRL = dr_ctrl;
  assign O_DBG_STAT = dr_stat;
endmodule

// >>> logic/smm_chipset.sv
`timescale 1ns/100ps
module smm_chipset
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  smm_link_if.chipset link,
  input wire logic I_CYC,
  input wire logic I_STB,
  input wire logic I_WE,
  input wire logic [3:0] I_ADR,
  input wire logic [3:0] I_SEL,
  input wire logic [31:0] I_DAT,
  output logic [31:0] O_DAT,
  output logic O_ACK
);
  logic arm, next_arm;
  logic [7:0] wait_cnt, next_wait_cnt;
  logic [7:0] cnt, next_cnt;
  logic [7:0] smi_cnt, next_smi_cnt;
  logic [7:0] raised, next_raised;
  logic smi_n, next_smi_n;
  logic rdy_n, next_rdy_n;
  logic done, next_done;
  logic ack, next_ack;
  logic [31:0] dat, next_dat;
  logic req;

  assign req = I_CYC & I_STB & ~ack;

  always_comb
  begin
    next_arm = arm;
    next_wait_cnt = wait_cnt;
    next_cnt = cnt;
    next_smi_cnt = smi_cnt;
    next_raised = raised;
    next_smi_n = smi_n;
    next_rdy_n = 1'b1;
    next_done = done & link.io_cycle;
    next_ack = req;
    next_dat = 32'h0000_0000;
    // ******************************************
    // wishbone registers
    // ******************************************
    if (req)
    begin
      case (I_ADR)
        smm_pkg::CS_CTRL_ADR: next_dat = {31'h0000_0000, arm};
        smm_pkg::CS_WAIT_ADR: next_dat = {24'h00_0000, wait_cnt};
        smm_pkg::CS_STAT_ADR: next_dat = {16'h0000, raised, 7'h00, link.smm_active};
        default: next_dat = 32'h0000_0000;
      endcase
      if (I_WE && I_SEL[0])
      begin
        if (I_ADR == smm_pkg::CS_CTRL_ADR)
        begin
          next_arm = I_DAT[smm_pkg::CS_ARM_BIT];
          if (I_DAT[smm_pkg::CS_RAISE_BIT])
            next_smi_n = 1'b0;
        end
        if (I_ADR == smm_pkg::CS_WAIT_ADR)
          next_wait_cnt = I_DAT[7:0];
      end
    end
    // ******************************************
    // I/O cycle answer and trap
    // ******************************************
    if (link.io_cycle && !done)
    begin
      next_cnt = cnt + 8'h01;
      if (arm && smi_n)
      begin
        next_smi_n = 1'b0;
        next_arm = 1'b0;
      end
      // hold ready back until the interrupt has led it far enough
      if (cnt >= wait_cnt && (smi_n || smi_cnt >= smm_pkg::TRAP_HOLD))
      begin
        next_rdy_n = 1'b0;
        next_done = 1'b1;
        next_cnt = 8'h00;
      end
    end
    if (!smi_n)
      next_smi_cnt = (smi_cnt == 8'hff) ? smi_cnt : smi_cnt + 8'h01;
    if (!smi_n && link.smm_active)
    begin
      next_smi_n = 1'b1;
      next_smi_cnt = 8'h00;
      next_raised = raised + 8'h01;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      arm <= 1'b0;
      wait_cnt <= smm_pkg::CS_WAIT_RESET;
      cnt <= 8'h00;
      smi_cnt <= 8'h00;
      raised <= 8'h00;
      smi_n <= 1'b1;
      rdy_n <= 1'b1;
      done <= 1'b0;
      ack <= 1'b0;
      dat <= 32'h0000_0000;
    end
    else
    begin
      arm <= next_arm;
      wait_cnt <= next_wait_cnt;
      cnt <= next_cnt;
      smi_cnt <= next_smi_cnt;
      raised <= next_raised;
      smi_n <= next_smi_n;
      rdy_n <= next_rdy_n;
      done <= next_done;
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  assign link.mgmt_interrupt_n = smi_n;
  assign link.burst_ready_n = rdy_n;
  assign O_DAT = dat;
  assign O_ACK = ack;
endmodule

// >>> dv/smm_link_chk.sv
`timescale 1ns/100ps
module smm_link_chk
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic mgmt_interrupt_n,
  input wire logic burst_ready_n,
  input wire logic io_cycle,
  input wire logic halt_cycle,
  input wire logic smm_active
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // ******************************************
  // link timing
  // ******************************************
  entry_late_a: assert property ($fell(mgmt_interrupt_n) && !smm_active |-> ##[1:16] smm_active)
    else $error("entry late");
  irq_hold_a: assert property (!mgmt_interrupt_n && !smm_active |=> !mgmt_interrupt_n)
    else $error("interrupt dropped early");
  irq_release_a: assert property ($rose(smm_active) |-> ##[1:2] mgmt_interrupt_n)
    else $error("interrupt not released");
  ready_pulse_a: assert property (!burst_ready_n |=> burst_ready_n)
    else $error("ready too long");
  ready_io_a: assert property (!burst_ready_n |-> io_cycle)
    else $error("ready outside io cycle");
  trap_lead_a: assert property (!burst_ready_n && !mgmt_interrupt_n |-> $past(mgmt_interrupt_n, 3) == 1'b0)
    else $error("interrupt lead short");
  trap_entry_a: assert property (!burst_ready_n && !mgmt_interrupt_n |-> ##[1:10] smm_active)
    else $error("trap not taken");
  io_close_a: assert property (!burst_ready_n |-> ##[1:4] !io_cycle)
    else $error("io cycle open");
  smm_no_io_a: assert property (smm_active |-> !io_cycle)
    else $error("io cycle in mode");
  halt_pulse_a: assert property (halt_cycle |=> !halt_cycle)
    else $error("halt cycle too long");
  halt_out_a: assert property (halt_cycle |-> !smm_active)
    else $error("halt cycle in mode");
  cover property (!burst_ready_n && !mgmt_interrupt_n);
  cover property ($rose(smm_active));
  cover property (halt_cycle);
endmodule

// >>> dv/tb_smm_state_slot_control.sv
`timescale 1ns/100ps
module tb_smm_state_slot_control;
  // ******************************************
  // signals and design
  // ******************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic io_instr, io_in, io_str, io_rep, io_done, halted, dbg_trap, resume, interrupt_return_instruction, nmi, nmi_mask;
  logic slot_we, cyc, stb, wwe, shutdown, hret, reexec, dbg_take, nmi_take, nmi_mask_o, ack;
  logic smm_o;
  logic [31:0] dbg_ctrl_i, dbg_stat_i, dbg_stat_o;
  logic [3:0] adr;
  logic [15:0] io_port, slot_addr;
  logic [31:0] slot_wdata, wdat, slot_rdata, entry_pc, save_top, save_bot, dbg_ctrl_o, dat_o;
  logic [7:0] dbg_cnt = 8'h0;
  logic [7:0] halt_cnt = 8'h0;
  logic [7:0] hret_cnt = 8'h0;
  int compares = 0;
  int miscompares = 0;
  smm_link_if link();
  smm_slot_device i_smm_slot_device
  (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .link(link), .I_IO_INSTR(io_instr), .I_IO_PORT(io_port),
    .I_IO_IN(io_in), .I_IO_STRING(io_str), .I_IO_REP(io_rep), .I_IO_DONE(io_done),
    .I_HALTED(halted), .I_DEBUG_TRAP(dbg_trap), .I_RESUME(resume), .I_INTERRUPT_RETURN_INSTRUCTION_DONE(interrupt_return_instruction),
    .I_NMI(nmi), .I_NMI_MASK(nmi_mask), .I_DBG_CTRL(dbg_ctrl_i), .I_DBG_STAT(dbg_stat_i),
    .I_SLOT_WE(slot_we), .I_SLOT_ADDR(slot_addr), .I_SLOT_WDATA(slot_wdata),
    .O_SLOT_RDATA(slot_rdata), .O_SMM_ACTIVE(smm_o), .O_SHUTDOWN(shutdown), .O_ENTRY_PC(entry_pc),
    .O_SAVE_TOP(save_top), .O_SAVE_BOTTOM(save_bot), .O_HALT_RETURN(hret), .O_REEXEC(reexec),
    .O_DEBUG_TAKE(dbg_take), .O_NMI_TAKE(nmi_take), .O_NMI_MASK(nmi_mask_o),
    .O_DBG_CTRL(dbg_ctrl_o), .O_DBG_STAT(dbg_stat_o)
  );
  smm_chipset i_smm_chipset
  (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .link(link), .I_CYC(cyc), .I_STB(stb), .I_WE(wwe),
    .I_ADR(adr), .I_SEL(4'hf), .I_DAT(wdat), .O_DAT(dat_o), .O_ACK(ack)
  );
  smm_link_chk i_smm_link_chk
  (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .mgmt_interrupt_n(link.mgmt_interrupt_n),
    .burst_ready_n(link.burst_ready_n), .io_cycle(link.io_cycle),
    .halt_cycle(link.halt_cycle), .smm_active(link.smm_active)
  );
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (rst_b)
    begin
      dbg_cnt <= dbg_cnt + 8'(dbg_take);
      halt_cnt <= halt_cnt + 8'(link.halt_cycle);
      hret_cnt <= hret_cnt + 8'(hret);
    end
  end
  // ******************************************
  // tasks
  // ******************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= we;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    wwe <= 1'b0;
    if (!we) chk(dat_o & m, e);
  endtask
  task automatic swr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    slot_we <= 1'b1;
    slot_addr <= a;
    slot_wdata <= d;
    @(posedge clk);
    slot_we <= 1'b0;
  endtask
  task automatic srd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    slot_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(slot_rdata & m, e);
  endtask
  task automatic enter;
    wb(1'b1, smm_pkg::CS_CTRL_ADR, 32'h2, 32'h0, 32'h0);
    while (link.smm_active !== 1'b1) @(posedge clk);
    chk({31'h0, smm_o}, 32'h1);
  endtask
  task automatic leave;
    @(posedge clk) resume <= 1'b1;
    @(posedge clk) resume <= 1'b0;
    while (link.smm_active !== 1'b0) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  // ******************************************
  // scenarios
  // ******************************************
  initial
  begin
    {io_instr, io_in, io_str, io_rep, io_done, halted, dbg_trap, resume, interrupt_return_instruction, nmi, nmi_mask} = '0;
    {slot_we, cyc, stb, wwe, adr, io_port, slot_addr, slot_wdata, wdat} = '0;
    dbg_ctrl_i = 32'ha5a5_0001;
    dbg_stat_i = 32'h0000_4002;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk(entry_pc, 32'h0003_8000);
    chk(save_top, 32'h0003_ffff);
    chk(save_bot, 32'h0003_fe00);
    wb(1'b0, smm_pkg::CS_WAIT_ADR, 32'h0, 32'hff, 32'h2);
    wb(1'b1, smm_pkg::CS_WAIT_ADR, 32'h6, 32'h0, 32'h0);
    wb(1'b0, smm_pkg::CS_WAIT_ADR, 32'h0, 32'hff, 32'h6);
    wb(1'b0, 4'hc, 32'h0, 32'hffff_ffff, 32'h0);
    // halted entry with masked nmi, then relocation
    halted <= 1'b1;
    nmi_mask <= 1'b1;
    enter();
    dbg_ctrl_i <= 32'h0000_0000;
    dbg_stat_i <= 32'h0000_0000;
    srd(16'hfef8, 32'hffff_ffff, 32'h0003_0000);
    srd(16'hff02, 32'hffff_ffff, 32'h1);
    swr(16'hff02, 32'hffff_ffff);
    srd(16'hff02, 32'hffff_ffff, 32'h1);
    srd(16'hff00, 32'hffff_ffff, 32'h0);
    srd(16'hffa4, 32'h2, 32'h0);
    chk(dbg_ctrl_o, 32'ha5a5_0001);
    chk(dbg_stat_o, 32'h0000_4002);
    nmi <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, nmi_take}, 32'h0);
    @(posedge clk) interrupt_return_instruction <= 1'b1;
    @(posedge clk) interrupt_return_instruction <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, nmi_take}, 32'h1);
    nmi <= 1'b0;
    swr(16'hfef8, 32'h0010_0000);
    leave();
    chk({31'h0, shutdown}, 32'h0);
    chk(entry_pc, 32'h0010_8000);
    chk(save_bot, 32'h0010_fe00);
    chk({24'h0, hret_cnt}, 32'h1);
    chk({24'h0, halt_cnt}, 32'h1);
    chk({31'h0, nmi_mask_o}, 32'h1);
    halted <= 1'b0;
    // trapped input string instruction, restart requested
    wb(1'b1, smm_pkg::CS_CTRL_ADR, 32'h1, 32'h0, 32'h0);
    io_port <= 16'h1234;
    {io_in, io_str, io_rep} <= 3'b111;
    io_instr <= 1'b1;
    // breakpoint while the interrupt waits inside the I/O cycle
    repeat (7) @(posedge clk);
    dbg_trap <= 1'b1;
    @(posedge clk) dbg_trap <= 1'b0;
    while (link.smm_active !== 1'b1) @(posedge clk);
    io_instr <= 1'b0;
    srd(16'hffa4, 32'hffff_ffff, 32'h1234_000f);
    srd(16'hff02, 32'hffff_ffff, 32'h0);
    swr(16'hffa4, 32'h0);
    srd(16'hffa4, 32'hffff_ffff, 32'h1234_000f);
    swr(16'hff00, 32'hffff_00ff);
    srd(16'hff00, 32'hffff_ffff, 32'h0000_00ff);
    leave();
    chk({31'h0, reexec}, 32'h1);
    chk({24'h0, dbg_cnt}, 32'h0);
    // second interrupt before the reexecution
    enter();
    srd(16'hffa4, 32'h2, 32'h0);
    srd(16'hff00, 32'hffff_ffff, 32'h0);
    leave();
    chk({31'h0, reexec}, 32'h1);
    chk({24'h0, dbg_cnt}, 32'h0);
    @(posedge clk) io_done <= 1'b1;
    @(posedge clk) io_done <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, reexec}, 32'h0);
    chk({24'h0, dbg_cnt}, 32'h1);
    // base off the 32 Kbyte grid
    enter();
    swr(16'hfef8, 32'h0010_4000);
    leave();
    chk({31'h0, shutdown}, 32'h1);
    wb(1'b0, smm_pkg::CS_STAT_ADR, 32'h0, 32'hff01, 32'h0400);
    end_sim();
  end
endmodule
